// >>> verilog/swts_defines.vh
// Constants for the single-wire thermostat slot logic
// Notes on behaviour
// RL1: One data bit per time slot, write or read, on the shared line.
// RL2: Master makes write slots at least 60 us with 1 us recovery.
// RL3: Master sends one by releasing the line within 15 us.
// RL4: Master sends zero by holding the line low the whole slot.
// RL5: Device samples written bit 15 to 60 us after the falling edge.
// RL6: Device drives data only inside read slots the master opens.
// RL7: Master makes read slots at least 60 us with 1 us recovery.
// RL8: Master opens a read slot with a low of at least 1 us.
// RL9: Device sends one by releasing, zero by pulling low, then releases.
// RL10: Read bit held valid 15 us after the slot-opening falling edge.
// RL11: Master keeps low and rise times short, samples late in window.
// RL12: Transaction is reset, presence, command byte, optional data byte.
// RL13: Commands 01h, 02h write trip points; A2h reads low trip point.
// RL14: Status write 06h sets power-up thermostat select and output polarity; code decodes 0Ch.
// RL15: Reset low 480 us; presence after 15-60 us, lasting 60-240 us.
// RL16: Also decode AAh, EEh, 22h, A1h high-trip read, ACh status read.
// RL17: Line low longer than 480 us is a reset, abandoning the transaction.
// RL18: Bytes shift least significant bit first, one bit per slot.
// RL19: Trip points are signed whole degrees Celsius, one count per degree.
`ifndef SWTS_DEFINES_VH
`define SWTS_DEFINES_VH

`define SWTS_CLK_MHZ 250
`define SWTS_SAMPLE_US 30
`define SWTS_SAMPLE_CYC (`SWTS_SAMPLE_US * `SWTS_CLK_MHZ)
`define SWTS_RDV_US 15
`define SWTS_RDV_CYC (`SWTS_RDV_US * `SWTS_CLK_MHZ)
`define SWTS_RST_US 480
`define SWTS_RST_CYC (`SWTS_RST_US * `SWTS_CLK_MHZ)
`define SWTS_PDH_US 30
`define SWTS_PDH_CYC (`SWTS_PDH_US * `SWTS_CLK_MHZ)
`define SWTS_PDL_US 120
`define SWTS_PDL_CYC (`SWTS_PDL_US * `SWTS_CLK_MHZ)

`define SWTS_CMD_WR_HIGH 8'h01
`define SWTS_CMD_WR_LOW 8'h02
`define SWTS_CMD_RD_HIGH 8'hA1
`define SWTS_CMD_RD_LOW 8'hA2
`define SWTS_CMD_WR_STAT 8'h0C
`define SWTS_CMD_RD_STAT 8'hAC
`define SWTS_CMD_RD_TEMP 8'hAA
`define SWTS_CMD_START 8'hEE
`define SWTS_CMD_STOP 8'h22

`define SWTS_STAT_POL_BIT 1
`define SWTS_STAT_TR_BIT 2
`define SWTS_STAT_RW_MASK 8'h07
`define SWTS_HIGH_RST 8'h00
`define SWTS_LOW_RST 8'h00
`define SWTS_STAT_RST 8'h00

`endif

// >>> verilog/swts_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module swts_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output reg [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign wr_ready_out = (count != DEPTH[AW:0]);
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  // Head word registered; pop advances to the next entry
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      rd_data_out <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
      if (count == {(AW+1){1'b0}} || (pop && count == {{AW{1'b0}}, 1'b1})) begin
        rd_data_out <= wr_data_in;
      end else if (pop) begin
        rd_data_out <= mem[(rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/swts_slave.v
// Slot timing and byte sequencing for the single-wire thermostat slave
`timescale 1ns/100ps
`default_nettype none
`include "swts_defines.vh"
module swts_slave #(
  parameter SAMPLE_CYC = `SWTS_SAMPLE_CYC,
  parameter RDV_CYC = `SWTS_RDV_CYC,
  parameter RST_CYC = `SWTS_RST_CYC,
  parameter PDH_CYC = `SWTS_PDH_CYC,
  parameter PDL_CYC = `SWTS_PDL_CYC,
  parameter CW = 18
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire line_in,
  output wire line_out,
  output wire line_oe_n_out,
  input wire [7:0] temperature_in,
  output reg [7:0] high_trip_point_out,
  output reg [7:0] low_trip_point_out,
  output reg [7:0] status_out,
  output reg conv_start_out,
  output reg conv_stop_out,
  output wire [7:0] cmd_data_out,
  output wire cmd_valid_out,
  input wire cmd_ready_in,
  output reg busy_out
);
  // ************************************************************
  // States
  // ************************************************************
  localparam ST_IDLE = 7'b0000001;
  localparam ST_RSTW = 7'b0000010;
  localparam ST_PDH = 7'b0000100;
  localparam ST_PDL = 7'b0001000;
  localparam ST_CMD = 7'b0010000;
  localparam ST_WDAT = 7'b0100000;
  localparam ST_RDAT = 7'b1000000;

  reg line_m;
  reg line_s;
  reg line_d;
  reg [6:0] state;
  reg [CW-1:0] low_cnt;
  reg [CW-1:0] slot_cnt;
  reg [CW-1:0] pcnt;
  reg in_slot;
  reg sampled;
  reg drive_low;
  reg [7:0] shreg;
  reg [2:0] bitn;
  reg [7:0] cmd;
  reg [7:0] next_shreg;
  reg [8:0] rd_src;
  wire fall;
  wire rise;
  wire is_reset;
  wire fifo_ready;
  reg fifo_push;

  assign fall = line_d && !line_s;
  assign rise = !line_d && line_s;
  // Counter saturates, so a stuck-low line keeps reporting reset
  assign is_reset = (low_cnt >= RST_CYC[CW-1:0]); // [RL17]
  // Open drain: only ever drives low, enable active low
  assign line_out = 1'b0;
  assign line_oe_n_out = !drive_low;

  // Classify a read-type command and fetch its byte
  function [8:0] swts_read_src;
    input [7:0] c;
    input [7:0] th;
    input [7:0] tl;
    input [7:0] st;
    input [7:0] tp;
    begin
      case (c)
        `SWTS_CMD_RD_HIGH: swts_read_src = {1'b1, th}; // [RL16]
        `SWTS_CMD_RD_LOW: swts_read_src = {1'b1, tl}; // [RL13]
        `SWTS_CMD_RD_STAT: swts_read_src = {1'b1, st}; // [RL16]
        `SWTS_CMD_RD_TEMP: swts_read_src = {1'b1, tp}; // [RL16]
        default: swts_read_src = 9'h000;
      endcase
    end
  endfunction

  function swts_is_write;
    input [7:0] c;
    begin
      swts_is_write = (c == `SWTS_CMD_WR_HIGH) || (c == `SWTS_CMD_WR_LOW) ||
        (c == `SWTS_CMD_WR_STAT);
    end
  endfunction

  // ************************************************************
  // Line synchroniser and low-time measure
  // ************************************************************
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      line_m <= 1'b1;
      line_s <= 1'b1;
      line_d <= 1'b1;
      low_cnt <= {CW{1'b0}};
    end else begin
      line_m <= line_in;
      line_s <= line_m;
      line_d <= line_s;
      if (line_s) begin
        low_cnt <= {CW{1'b0}};
      end else if (!is_reset) begin
        low_cnt <= low_cnt + 1'b1;
      end
    end
  end

  // Bit shifted in at the sample point, least significant first
  always @* begin
    next_shreg = {line_s, shreg[7:1]}; // [RL18]
    rd_src = swts_read_src(next_shreg, high_trip_point_out, low_trip_point_out, status_out,
      temperature_in);
  end

  // ************************************************************
  // Slot and transaction sequencer
  // ************************************************************
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      slot_cnt <= {CW{1'b0}};
      pcnt <= {CW{1'b0}};
      in_slot <= 1'b0;
      sampled <= 1'b0;
      drive_low <= 1'b0;
      shreg <= 8'h00;
      bitn <= 3'd0;
      cmd <= 8'h00;
      high_trip_point_out <= `SWTS_HIGH_RST;
      low_trip_point_out <= `SWTS_LOW_RST;
      status_out <= `SWTS_STAT_RST;
      conv_start_out <= 1'b0;
      conv_stop_out <= 1'b0;
      fifo_push <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      conv_stop_out <= 1'b0;
      fifo_push <= 1'b0;
      busy_out <= (state != ST_IDLE);
      if (in_slot) begin
        slot_cnt <= slot_cnt + 1'b1;
      end
      if (is_reset && state != ST_RSTW) begin
        // Abandon whatever was in progress
        state <= ST_RSTW; // [RL17]
        drive_low <= 1'b0;
        in_slot <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            drive_low <= 1'b0;
          end
          ST_RSTW: begin
            if (rise) begin
              state <= ST_PDH; // [RL15]
              pcnt <= {CW{1'b0}};
            end
          end
          ST_PDH: begin
            pcnt <= pcnt + 1'b1;
            if (pcnt == PDH_CYC[CW-1:0] - 1'b1) begin
              drive_low <= 1'b1; // [RL15]
              pcnt <= {CW{1'b0}};
              state <= ST_PDL;
            end
          end
          ST_PDL: begin
            pcnt <= pcnt + 1'b1;
            if (pcnt == PDL_CYC[CW-1:0] - 1'b1) begin
              drive_low <= 1'b0; // [RL15]
              state <= ST_CMD; // [RL12]
              bitn <= 3'd0;
              in_slot <= 1'b0;
            end
          end
          ST_CMD, ST_WDAT: begin
            // A falling edge outside a slot opens one slot carrying one bit
            if (fall && !in_slot) begin
              in_slot <= 1'b1; // [RL1]
              sampled <= 1'b0;
              slot_cnt <= {CW{1'b0}};
            end else if (in_slot && !sampled && slot_cnt == SAMPLE_CYC[CW-1:0]) begin
              sampled <= 1'b1; // [RL5]
              shreg <= next_shreg;
              bitn <= bitn + 1'b1;
              if (bitn == 3'd7) begin
                if (state == ST_CMD) begin
                  cmd <= next_shreg;
                  fifo_push <= 1'b1;
                  if (next_shreg == `SWTS_CMD_START) begin
                    conv_start_out <= 1'b1; // [RL16]
                  end
                  if (next_shreg == `SWTS_CMD_STOP) begin
                    conv_stop_out <= 1'b1; // [RL16]
                  end
                  if (swts_is_write(next_shreg)) begin
                    state <= ST_WDAT; // [RL12]
                  end else if (rd_src[8]) begin
                    shreg <= rd_src[7:0]; // [RL6]
                    // Free the slot flag so the first read slot's fall is seen
                    in_slot <= 1'b0;
                    state <= ST_RDAT;
                  end else begin
                    state <= ST_IDLE;
                  end
                end else begin
                  // Trip points stored as signed whole degrees
                  case (cmd)
                    `SWTS_CMD_WR_HIGH: high_trip_point_out <= next_shreg; // [RL13] [RL19]
                    `SWTS_CMD_WR_LOW: low_trip_point_out <= next_shreg; // [RL13] [RL19]
                    // 0Ch lands as power-up thermostat select plus polarity
                    default: status_out <= next_shreg & `SWTS_STAT_RW_MASK; // [RL14]
                  endcase
                  state <= ST_IDLE;
                end
              end
            end else if (in_slot && sampled && line_s) begin
              in_slot <= 1'b0;
            end
          end
          ST_RDAT: begin
            if (fall && !in_slot) begin
              in_slot <= 1'b1; // [RL6]
              slot_cnt <= {CW{1'b0}};
              drive_low <= !shreg[0]; // [RL9] [RL18]
            end else if (in_slot && slot_cnt == RDV_CYC[CW-1:0]) begin
              drive_low <= 1'b0; // [RL10] [RL9]
              shreg <= {1'b0, shreg[7:1]};
              bitn <= bitn + 1'b1;
              in_slot <= 1'b0;
              if (bitn == 3'd7) begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Received command log
  // ************************************************************
  // A full log drops the entry rather than stalling the bus timing
  swts_fifo #(
    .WIDTH(8),
    .DEPTH(4),
    .AW(2)
  ) u_log (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_data_in(cmd),
    .wr_valid_in(fifo_push && fifo_ready),
    .wr_ready_out(fifo_ready),
    .rd_data_out(cmd_data_out),
    .rd_valid_out(cmd_valid_out),
    .rd_ready_in(cmd_ready_in)
  );
endmodule
`default_nettype wire

// >>> testbench/swts_slave_sva.sv
// Assertion checker for the single-wire thermostat slave ports
`timescale 1ns/100ps
`default_nettype none
module swts_slave_sva #(
  parameter int RST_CYC = 480,
  parameter int PDH_CYC = 30,
  parameter int PDL_CYC = 120
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_n_out,
  input wire logic [7:0] high_trip_point_out,
  input wire logic [7:0] low_trip_point_out,
  input wire logic [7:0] status_out,
  input wire logic conv_start_out,
  input wire logic conv_stop_out,
  input wire logic [7:0] cmd_data_out,
  input wire logic cmd_valid_out,
  input wire logic cmd_ready_in,
  input wire logic busy_out
);
  // Sync lag plus registered output gives a few cycles of slack
  localparam int PD_MAX = PDH_CYC + 8;
  localparam int DRV_MAX = PDL_CYC + 4;
  logic [15:0] low_cnt;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) low_cnt <= 16'h0000;
    else if (line_in) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence bus_reset_s;
    !line_in && low_cnt >= RST_CYC ##1 line_in;
  endsequence
  line_zero_a: assert property (line_out == 1'b0)
    else $error("data output not zero");
  start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse too long");
  stop_pulse_a: assert property (conv_stop_out |=> !conv_stop_out)
    else $error("stop pulse too long");
  idle_release_a: assert property (!busy_out |-> line_oe_n_out)
    else $error("line driven while idle");
  drive_end_a: assert property ($fell(line_oe_n_out) |-> ##[1:DRV_MAX] line_oe_n_out)
    else $error("line drive not released");
  long_low_a: assert property (low_cnt > RST_CYC + 4 |-> line_oe_n_out)
    else $error("line driven during reset");
  presence_a: assert property (bus_reset_s |-> ##[PDH_CYC:PD_MAX] !line_oe_n_out)
    else $error("presence missing");
  log_hold_a: assert property (cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_data_out))
    else $error("log head lost");
  status_mask_a: assert property (status_out[7:3] == 5'h00)
    else $error("status upper bits set");
  trip_busy_a: assert property (!$stable({high_trip_point_out, low_trip_point_out}) |-> $past(busy_out))
    else $error("trip point changed while idle");
endmodule
bind swts_slave swts_slave_sva #(.RST_CYC(RST_CYC), .PDH_CYC(PDH_CYC), .PDL_CYC(PDL_CYC)) chk (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .line_in(line_in), .line_out(line_out),
  .line_oe_n_out(line_oe_n_out), .high_trip_point_out(high_trip_point_out),
  .low_trip_point_out(low_trip_point_out), .status_out(status_out),
  .conv_start_out(conv_start_out), .conv_stop_out(conv_stop_out), .cmd_data_out(cmd_data_out),
  .cmd_valid_out(cmd_valid_out), .cmd_ready_in(cmd_ready_in), .busy_out(busy_out));
`default_nettype wire

// >>> testbench/swts_bus_master.sv
// Bus master model issuing reset pulses and time slots
`timescale 1ns/100ps
`default_nettype none
module swts_bus_master (
  input wire logic sys_clk_in,
  input wire logic line_in,
  output logic line_pull_out
);
  initial line_pull_out = 1'b0;
  task automatic hold(input logic pull, input int n);
    line_pull_out <= pull;
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    hold(1'b1, 500);
    line_pull_out <= 1'b0;
    repeat (300) begin
      @(posedge sys_clk_in);
      if (line_in === 1'b0) seen = 1'b1;
    end
  endtask
  task automatic write_bits(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      hold(1'b1, d[i] ? 5 : 64);
      hold(1'b0, d[i] ? 64 : 5);
    end
  endtask
  task automatic read_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      hold(1'b1, 2);
      hold(1'b0, 10);
      d[i] = line_in;
      hold(1'b0, 60);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Testbench for the single-wire thermostat slave
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk, resetn, cmd_ready, pull, oe_n, line_o, cv, start_p, stop_p, busy, seen;
  logic [7:0] hi, lo, st, cd, r, temp;
  int n_errors = 0, n_tests = 0, n_start = 0, n_stop = 0;
  // Command, data, expected output or read value
  logic [23:0] rows [7] = '{24'h012828, 24'h020A0A, 24'hA10028, 24'hA2000A,
                            24'h0C0606, 24'hAC0006, 24'hAA003C};
  wire logic line = !pull && oe_n;
  swts_slave #(.SAMPLE_CYC(30), .RDV_CYC(15), .RST_CYC(480), .PDH_CYC(30), .PDL_CYC(120))
    dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .line_in(line), .line_out(line_o),
    .line_oe_n_out(oe_n), .temperature_in(temp), .high_trip_point_out(hi),
    .low_trip_point_out(lo), .status_out(st), .conv_start_out(start_p),
    .conv_stop_out(stop_p), .cmd_data_out(cd), .cmd_valid_out(cv),
    .cmd_ready_in(cmd_ready), .busy_out(busy));
  swts_bus_master m (.sys_clk_in(sys_clk), .line_in(line), .line_pull_out(pull));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (start_p === 1'b1) n_start++;
    if (stop_p === 1'b1) n_stop++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic xact(input logic [7:0] c, input logic [7:0] d, input logic more);
    m.bus_reset(seen);
    chk({7'h00, seen}, 8'h01);
    m.write_bits(c, 8);
    if (more && c[7]) m.read_byte(r);
    else if (more) m.write_bits(d, 8);
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    resetn = 1'b0;
    cmd_ready = 1'b0;
    temp = 8'h3C;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    chk({busy, oe_n, cv, line_o, 4'h0}, 8'h40);
    @(posedge sys_clk);
    foreach (rows[i]) begin
      xact(rows[i][23:16], rows[i][15:8], 1'b1);
      case (rows[i][23:16])
        8'h01: chk(hi, rows[i][7:0]);
        8'h02: chk(lo, rows[i][7:0]);
        8'h0C: chk(st, rows[i][7:0]);
        default: chk(r, rows[i][7:0]);
      endcase
    end
    // Log held back so far: only the first four commands fit
    for (int i = 0; i < 4; i++) begin
      chk({7'h00, cv}, 8'h01);
      chk(cd, rows[i][23:16]);
      cmd_ready <= 1'b1;
      @(posedge sys_clk);
      cmd_ready <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    chk({7'h00, cv}, 8'h00);
    cmd_ready <= 1'b1;
    xact(8'hEE, 8'h00, 1'b0);
    xact(8'h22, 8'h00, 1'b0);
    chk(n_start[7:0], 8'h01);
    chk(n_stop[7:0], 8'h01);
    // Negative reading, signed whole degrees, taken at command end
    temp <= 8'hE7;
    xact(8'hAA, 8'h00, 1'b1);
    chk(r, 8'hE7);
    m.bus_reset(seen);
    m.write_bits(8'h01, 4);
    xact(8'h02, 8'h80, 1'b1);
    chk(lo, 8'h80);
    chk(hi, 8'h28);
    xact(8'h0C, 8'hFF, 1'b1);
    chk(st, 8'h07);
    xact(8'h55, 8'h00, 1'b1);
    chk(hi, 8'h28);
    chk(lo, 8'h80);
    test_done;
  end
  // Roughly 25000 cycles expected; generous margin before giving up
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    test_done;
  end
endmodule
`default_nettype wire
